// >>> hdl/ucpps_pkg.sv
/*
  constants, types and register map of the upstream charger / port power status bank.
  assumes an apb master with 32-bit data; registers sit at four times their index.
*/
package ucpps_pkg;
  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int NPORT = 4;
  localparam int NCMP = 4;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_CMP_STAT = 14'h30e4;
  localparam logic [13:0] IDX_PWR_STAT = 14'h30e5;
  localparam logic [13:0] IDX_OC_STAT = 14'h30e6;
  localparam logic [13:0] IDX_MODE = 14'h30ec;
  // register selects, one-hot
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_CMP = 4'h1;
  localparam logic [3:0] SEL_PWR = 4'h2;
  localparam logic [3:0] SEL_OC = 4'h4;
  localparam logic [3:0] SEL_MODE = 4'h8;
  // reset value common to all four registers
  localparam logic [7:0] REG_RST = 8'h00;
  // comparator status field layout
  localparam int CMP_HI_BIT = 3;
  localparam int CMP_DM_BIT = 2;
  localparam int CMP_DP_BIT = 1;
  localparam int CMP_VDAT_BIT = 0;
  // per-port field of power and over-current registers
  localparam int PORT_LSB = 1;
  localparam int PORT_MSB = 4;
  // mode register fields
  localparam int MODE_KEEP_BIT = 5;
  localparam int MODE_VEND_BIT = 3;
  localparam int MODE_ENH_BIT = 2;
  localparam logic [7:0] MODE_RW_MASK = 8'h2c;
  // charger type codes
  localparam logic [2:0] CT_DCP = 3'h1;
  localparam logic [2:0] CT_CDP = 3'h2;
  // zero fill for read data
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
  localparam logic [1:0] ALIGN_OK = 2'h0;
  // comparator outputs travel together
  typedef struct packed {
    logic dminus_high_current_flag; // d- above the high-current threshold
    logic dminus_single_ended_rx; // d- single-ended receiver
    logic dplus_single_ended_rx; // d+ single-ended receiver
    logic data_voltage_detect; // data-line voltage detect comparator
  } ucpps_cmp_t;
  // detection mode controls handed to the sequencer
  typedef struct packed {
    logic keep_data_voltage_source; // source stays on through connect
    logic vendor_charger_search_en; // look for divider-type chargers
    logic enhanced_detect_en; // reverse the source to split charger kinds
  } ucpps_mode_t;
  // apb slave states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESP = 3'b100
  } ucpps_apb_st_t;
endpackage : ucpps_pkg

// >>> hdl/ucpps_sync.sv
/*
  two-flop synchroniser for a bundle of independent levels.
  assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ns
module ucpps_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg; // first stage, read by q_reg only
  logic [W-1:0] q_reg; // second stage
  // two flops; only the second stage is visible to logic
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule : ucpps_sync

// >>> hdl/ucpps_type_map.sv
/*
  charger type reporting: folds the charging-port code into the dedicated
  charger code when enhanced detection is off.
  assumes raw type from the detection sequencer on the same clock.
*/
`timescale 1ns/1ns
module ucpps_type_map
  import ucpps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // sequencer result and mode
  input wire logic [2:0] raw_type,
  input wire logic enh_on,
  // reported code
  output logic [2:0] type_code
);
  logic [2:0] code_reg; // registered report
  // without the reversed source the two charger kinds look alike
  always_ff @(posedge clk) begin
    if (srst) begin
      code_reg <= CT_DCP ^ CT_DCP;
    end else if (!enh_on && raw_type == CT_CDP) begin
      code_reg <= CT_DCP;
    end else begin
      code_reg <= raw_type;
    end
  end
  assign type_code = code_reg;
endmodule : ucpps_type_map

// >>> hdl/ucpps_bank.sv
/*
  upstream charger comparator, port power and over-current status bank with the
  charger detection mode register, reached over apb.
  assumes comparator and over-current inputs arrive asynchronously, while port
  power requests and the raw charger type come from logic on clk.
*/
`timescale 1ns/1ns
// Behaviour
// - bit 3 shows D- above high threshold
// - bit 2 shows D- single-ended receiver
// - bit 1 shows D+ single-ended receiver
// - bit 0 shows data voltage detect
// - power bit set for host-enabled port
// - power bit zero if disabled or over-current
// - power bits are read-only indications
// - per-port over-current flags in bits 4:1
// - over-current clears that port's power bit
// - mode bit 5 keeps voltage source on
// - mode bit 3 enables vendor charger search
// - mode bit 2 enables source reversal
// - enhanced off folds code 010 into 001
module ucpps_bank
  import ucpps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ucpps_pkg::ADDR_W-1:0] paddr,
  input wire logic [ucpps_pkg::DATA_W-1:0] pwdata,
  output logic [ucpps_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparator outputs, asynchronous
  input wire ucpps_pkg::ucpps_cmp_t cmp_raw,
  // over-current indications per port, asynchronous
  input wire logic [ucpps_pkg::NPORT-1:0] port_overcurrent_flag,
  // host power requests per port, on clk
  input wire logic [ucpps_pkg::NPORT-1:0] port_power_enabled,
  // raw result of the detection sequencer, on clk
  input wire logic [2:0] raw_charger_type,
  // controls to the detection sequencer
  output ucpps_pkg::ucpps_mode_t mode_ctl,
  // status to hub logic
  output logic [ucpps_pkg::NPORT-1:0] port_power_status,
  output logic [2:0] charger_type_code
);
  import ucpps_pkg::*;

  // every check below runs on clk and stays quiet while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // decode a byte address into a one-hot register select
  function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [3:0] s;
    s = SEL_NONE;
    if (a[1:0] == ALIGN_OK) begin
      case (a[ADDR_W-1:2])
        IDX_CMP_STAT: s = SEL_CMP;
        IDX_PWR_STAT: s = SEL_PWR;
        IDX_OC_STAT: s = SEL_OC;
        IDX_MODE: s = SEL_MODE;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : reg_sel

  // synchronised views of the asynchronous inputs
  logic [NCMP-1:0] cmp_sync; // comparator bundle after two flops
  logic [NPORT-1:0] oc_sync; // over-current after two flops

  // apb slave state
  ucpps_apb_st_t st_reg; // current state
  ucpps_apb_st_t st_next; // next state
  logic [DATA_W-1:0] prdata_reg; // captured read data
  logic pready_reg; // one-cycle answer
  logic pslverr_reg; // error with the answer
  logic [3:0] sel_reg; // register chosen in the access phase
  logic wr_commit; // write takes effect at this edge

  // register storage
  logic [7:0] mode_reg; // detection mode, rw bits only
  logic [NPORT-1:0] pwr_reg; // port power status
  logic [NPORT-1:0] oc_reg; // over-current status
  logic [NCMP-1:0] cmp_reg; // comparator status
  ucpps_mode_t mode_ctl_reg; // controls driven to the sequencer

  // comparators cross into clk before anything reads them
  ucpps_sync #(
    .W(NCMP)
  ) u_cmp_sync (
    .clk(clk),
    .srst(srst),
    .d(cmp_raw),
    .q(cmp_sync)
  );

  // over-current pins cross the same way
  ucpps_sync #(
    .W(NPORT)
  ) u_oc_sync (
    .clk(clk),
    .srst(srst),
    .d(port_overcurrent_flag),
    .q(oc_sync)
  );

  // charger type report follows the enhanced detect setting
  ucpps_type_map u_type_map (
    .clk(clk),
    .srst(srst),
    .raw_type(raw_charger_type),
    .enh_on(mode_ctl_reg.enhanced_detect_en),
    .type_code(charger_type_code)
  );

  // a write lands only at the edge where the master sees pready
  assign wr_commit = (st_reg == ST_RESP) && psel && penable && pwrite && pready_reg;

  // next state: one wait state, then a single answer cycle
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (psel && !penable) begin
          st_next = ST_WAIT; // setup seen
        end
      end
      ST_WAIT: begin
        if (psel && penable) begin
          st_next = ST_RESP; // answer next cycle
        end else if (!psel) begin
          st_next = ST_IDLE; // master gave up
        end
      end
      ST_RESP: begin
        st_next = ST_IDLE; // answer is seen at this edge
      end
      default: begin
        st_next = ST_IDLE; // recover from an illegal code
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // answer: pready and pslverr for exactly one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      sel_reg <= SEL_NONE;
    end else if (st_reg == ST_WAIT && psel && penable) begin
      pready_reg <= 1'b1;
      sel_reg <= reg_sel(paddr);
      // unmapped or misaligned address is refused
      pslverr_reg <= (reg_sel(paddr) == SEL_NONE);
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // read data captured in the access phase; reserved bits stay zero
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_reg <= RD_ZERO;
    end else if (st_reg == ST_WAIT && psel && penable && !pwrite) begin
      prdata_reg <= RD_ZERO;
      case (reg_sel(paddr))
        SEL_CMP: prdata_reg[NCMP-1:0] <= cmp_reg;
        SEL_PWR: prdata_reg[PORT_MSB:PORT_LSB] <= pwr_reg;
        SEL_OC: prdata_reg[PORT_MSB:PORT_LSB] <= oc_reg;
        SEL_MODE: prdata_reg[7:0] <= mode_reg & MODE_RW_MASK;
        default: prdata_reg <= RD_ZERO; // nothing there
      endcase
    end else if (pready_reg) begin
      prdata_reg <= RD_ZERO; // idle bus reads as zero
    end
  end

  // comparator status: plain sampled copy, no software path into it
  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_reg <= REG_RST[NCMP-1:0];
    end else begin
      cmp_reg <= cmp_sync;
    end
  end

  // over-current status mirrors the pins; software writes are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      oc_reg <= REG_RST[PORT_MSB:PORT_LSB];
    end else begin
      oc_reg <= oc_sync;
    end
  end

  // port power status: host request, forced low by over-current.
  // reading oc_sync, not oc_reg, keeps the status from lagging the flag.
  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_reg <= REG_RST[PORT_MSB:PORT_LSB];
    end else begin
      pwr_reg <= port_power_enabled & ~oc_sync;
    end
  end

  // mode register: only bits 5, 3 and 2 are writable
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= REG_RST;
    end else if (wr_commit && sel_reg == SEL_MODE) begin
      mode_reg <= pwdata[7:0] & MODE_RW_MASK;
    end
  end

  // controls to the sequencer track the mode register one cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_ctl_reg <= '0;
    end else begin
      mode_ctl_reg.keep_data_voltage_source <= mode_reg[MODE_KEEP_BIT];
      mode_ctl_reg.vendor_charger_search_en <= mode_reg[MODE_VEND_BIT];
      mode_ctl_reg.enhanced_detect_en <= mode_reg[MODE_ENH_BIT];
    end
  end

  // outputs come straight from flops; status bits have no write path
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mode_ctl = mode_ctl_reg;
  assign port_power_status = pwr_reg;

  // checks

  // a setup cycle in idle followed by the access phase
  sequence s_setup;
    st_reg == ST_IDLE && psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  // a read of a chosen register
  sequence s_rd(logic [3:0] s);
    st_reg == ST_WAIT && psel && penable && !pwrite && reg_sel(paddr) == s;
  endsequence
  // an access phase to an address that maps to nothing
  sequence s_bad;
    st_reg == ST_WAIT && psel && penable && reg_sel(paddr) == SEL_NONE;
  endsequence
  // a write access phase aimed at one of the three status registers
  sequence s_wr_stat;
    st_reg == ST_WAIT && psel && penable && pwrite && (reg_sel(paddr) & ~SEL_MODE) != SEL_NONE;
  endsequence

  // answer comes exactly one cycle after the access phase starts
  a_ready_timing: assert property (s_setup ##1 s_access |=> pready && !$past(pready))
    else $error("pready not one cycle after access start");
  // answer lasts one cycle
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held more than one cycle");
  // comparator read returns the sampled comparator levels
  a_cmp_read: assert property (s_rd(SEL_CMP) |=> prdata[NCMP-1:0] == $past(cmp_reg))
    else $error("comparator read data wrong");
  // comparator status follows the synchronised inputs
  a_cmp_track: assert property (cmp_reg == $past(cmp_sync))
    else $error("comparator status not tracking");
  // reserved comparator bits read zero
  a_cmp_resv: assert property (s_rd(SEL_CMP) |=> prdata[DATA_W-1:NCMP] == '0)
    else $error("reserved bits not zero");
  // power status equals request masked by over-current
  a_pwr_value: assert property (
    pwr_reg == ($past(port_power_enabled) & ~$past(oc_sync)))
    else $error("port power status wrong");
  // over-current port never shows power two cycles on
  a_pwr_oc_clear: assert property (
    ((oc_sync & pwr_reg) != '0) |-> $past(oc_sync) != oc_sync)
    else $error("power bit set on over-current port");
  // disabled port never shows power
  a_pwr_disabled: assert property ((pwr_reg & ~$past(port_power_enabled)) == '0)
    else $error("power bit set on disabled port");
  // a write to the power status register leaves it untouched
  a_pwr_ro: assert property (wr_commit && sel_reg == SEL_PWR |=>
    pwr_reg == ($past(port_power_enabled) & ~$past(oc_sync)))
    else $error("power status took a write");
  // keep-source control follows a committed mode write two edges later
  a_mode_keep: assert property (wr_commit && sel_reg == SEL_MODE |->
    ##2 mode_ctl.keep_data_voltage_source == $past(pwdata[MODE_KEEP_BIT], 2))
    else $error("keep source control wrong");
  a_mode_vend: assert property (wr_commit && sel_reg == SEL_MODE |->
    ##2 mode_ctl.vendor_charger_search_en == $past(pwdata[MODE_VEND_BIT], 2))
    else $error("vendor search control wrong");
  a_mode_enh: assert property (wr_commit && sel_reg == SEL_MODE |->
    ##2 mode_ctl.enhanced_detect_en == $past(pwdata[MODE_ENH_BIT], 2))
    else $error("enhanced detect control wrong");
  // with enhanced detection off on two edges in a row the charging-port code never appears
  a_type_fold: assert property (!mode_ctl.enhanced_detect_en ##1
    !mode_ctl.enhanced_detect_en |-> charger_type_code != CT_CDP)
    else $error("charging port code shown with enhanced off");
  // over-current status mirrors the synchronised pins one cycle late
  a_oc_track: assert property (oc_reg == $past(oc_sync))
    else $error("over-current status not tracking");
  // an error answer always rides on pready
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // read data is zero outside the answer cycle
  a_rdata_idle: assert property (!pready |-> prdata == RD_ZERO)
    else $error("read data not zero while idle");
  // an answer only follows an access phase
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without an access phase");
  // power read returns the status in bits 4:1
  a_pwr_read: assert property (s_rd(SEL_PWR) |=>
    prdata[PORT_MSB:PORT_LSB] == $past(pwr_reg))
    else $error("power status read wrong");
  // reserved power bits read zero
  a_pwr_resv: assert property (s_rd(SEL_PWR) |=>
    prdata[PORT_LSB-1:0] == '0 && prdata[DATA_W-1:PORT_MSB+1] == '0)
    else $error("reserved power bits not zero");
  // over-current read returns the flags in bits 4:1
  a_oc_read: assert property (s_rd(SEL_OC) |=>
    prdata[PORT_MSB:PORT_LSB] == $past(oc_reg))
    else $error("over-current status read wrong");
  // reserved over-current bits read zero
  a_oc_resv: assert property (s_rd(SEL_OC) |=>
    prdata[PORT_LSB-1:0] == '0 && prdata[DATA_W-1:PORT_MSB+1] == '0)
    else $error("reserved over-current bits not zero");
  // mode bits other than 5, 3 and 2 read zero
  a_mode_resv: assert property (s_rd(SEL_MODE) |=>
    (prdata & ~{24'h0, MODE_RW_MASK}) == '0)
    else $error("reserved mode bits not zero");
  // the mode register moves only on a committed write to it
  a_mode_hold: assert property (!(wr_commit && sel_reg == SEL_MODE) |=>
    $stable(mode_reg))
    else $error("mode register changed without a write");
  // unmapped or misaligned access answers with an error
  a_bad_err: assert property (s_bad |=> pready && pslverr)
    else $error("bad address answered without error");
  // writes to status registers are taken without an error
  a_stat_wr_ok: assert property (s_wr_stat |=> pready && !pslverr)
    else $error("status register write refused");
  // with enhanced detection on, the sequencer code passes unchanged
  a_type_pass: assert property (mode_ctl.enhanced_detect_en |=>
    charger_type_code == $past(raw_charger_type))
    else $error("charger code altered with enhanced on");
endmodule : ucpps_bank

// >>> bench/ucpps_apb_host.sv
/*
  apb master standing in for the system processor; runs one transfer per go pulse.
  assumes go is offered only while no transfer is open, on the same clk.
*/
`timescale 1ns/1ns
module ucpps_apb_host
  import ucpps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // request from the bench
  input wire logic go,
  input wire logic go_write,
  input wire logic [ucpps_pkg::ADDR_W-1:0] go_addr,
  input wire logic [ucpps_pkg::DATA_W-1:0] go_wdata,
  output logic done,
  output logic [ucpps_pkg::DATA_W-1:0] got_rdata,
  output logic got_err,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ucpps_pkg::ADDR_W-1:0] paddr,
  output logic [ucpps_pkg::DATA_W-1:0] pwdata,
  input wire logic [ucpps_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // setup, access, then hold until pready; the answer is taken at that edge only
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (srst) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 16'h0000;
      pwdata <= 32'h0000_0000;
      got_rdata <= 32'h0000_0000;
      got_err <= 1'b0;
    end else if (!psel && go) begin
      // setup cycle
      psel <= 1'b1;
      pwrite <= go_write;
      paddr <= go_addr;
      pwdata <= go_wdata;
    end else if (psel && !penable) begin
      penable <= 1'b1;
    end else if (psel && pready) begin
      // release; stale write data is inverted so nothing leans on it
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~pwdata;
      got_rdata <= prdata;
      got_err <= pslverr;
      done <= 1'b1;
    end
  end
endmodule : ucpps_apb_host

// >>> bench/upstream_charger_port_power_status_test.sv
/*
  self-checking bench for the charger / port power status bank.
  assumes ucpps_bank and the host model; all inputs driven at rising edges.
*/
`timescale 1ns/1ns
module upstream_charger_port_power_status_test;
  import ucpps_pkg::*;
  // clock, reset, tallies
  logic clk = 1'b0;
  logic srst = 1'b1;
  int n_errors = 0;
  int cmp_count = 0;
  // bench to host model
  logic go = 1'b0;
  logic go_write = 1'b0;
  logic [ADDR_W-1:0] go_addr = 16'h0000;
  logic [DATA_W-1:0] go_wdata = 32'h0000_0000;
  logic done;
  logic [DATA_W-1:0] got_rdata;
  logic got_err;
  // apb wires
  logic psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  // status inputs and outputs
  ucpps_cmp_t cmp_raw = 4'h0;
  logic [NPORT-1:0] port_overcurrent_flag = 4'h0;
  logic [NPORT-1:0] port_power_enabled = 4'h0;
  logic [2:0] raw_charger_type = 3'h0;
  ucpps_mode_t mode_ctl;
  logic [NPORT-1:0] port_power_status;
  logic [2:0] charger_type_code;
  // byte addresses are four times the register index
  localparam logic [15:0] A_CMP = {IDX_CMP_STAT, 2'h0};
  localparam logic [15:0] A_PWR = {IDX_PWR_STAT, 2'h0};
  localparam logic [15:0] A_OC = {IDX_OC_STAT, 2'h0};
  localparam logic [15:0] A_MODE = {IDX_MODE, 2'h0};

  always #5 clk = ~clk;

  ucpps_apb_host i_host (.clk(clk), .srst(srst), .go(go), .go_write(go_write),
    .go_addr(go_addr), .go_wdata(go_wdata), .done(done), .got_rdata(got_rdata),
    .got_err(got_err), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ucpps_bank i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .port_overcurrent_flag(port_overcurrent_flag),
    .port_power_enabled(port_power_enabled), .raw_charger_type(raw_charger_type),
    .mode_ctl(mode_ctl), .port_power_status(port_power_status),
    .charger_type_code(charger_type_code));

  // single place the run ends
  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // compare four-state values so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // let n edges pass, then sample off the edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  // one apb transfer through the host model, bounded wait for completion
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    go_write <= wr;
    go_addr <= a;
    go_wdata <= d;
    @(posedge clk);
    go <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 40) begin
      wait_cyc(1);
      n++;
    end
    if (n >= 40) begin
      n_errors++;
      give_verdict();
    end
  endtask : apb

  // all four registers read zero after reset, without error
  task automatic t_reset();
    logic [15:0] al [4];
    al = '{A_CMP, A_PWR, A_OC, A_MODE};
    foreach (al[i]) begin
      apb(1'b0, al[i], 32'h0000_0000);
      chk(got_rdata, 32'h0000_0000);
      chk({31'h0, got_err}, 32'h0000_0000);
    end
  endtask : t_reset

  // each comparator walks to its own bit; writes there change nothing
  task automatic t_cmp();
    for (int i = 0; i < NCMP; i++) begin
      @(posedge clk);
      cmp_raw <= 4'h1 << i;
      wait_cyc(3);
      apb(1'b0, A_CMP, 32'h0000_0000);
      chk(got_rdata, 32'h1 << i);
    end
    apb(1'b1, A_CMP, 32'hffff_ffff);
    apb(1'b0, A_CMP, 32'h0000_0000);
    chk(got_rdata, 32'h0000_0008);
  endtask : t_cmp

  // host enables, then an over-current on port 1 knocks its power bit out
  task automatic t_power();
    @(posedge clk);
    port_power_enabled <= 4'hb;
    wait_cyc(2);
    chk({28'h0, port_power_status}, 32'h0000_000b);
    apb(1'b0, A_PWR, 32'h0000_0000);
    chk(got_rdata, 32'h0000_0016);
    @(posedge clk);
    port_overcurrent_flag <= 4'h2;
    wait_cyc(4);
    chk({28'h0, port_power_status}, 32'h0000_0009);
    apb(1'b1, A_PWR, 32'hffff_ffff);
    apb(1'b0, A_PWR, 32'h0000_0000);
    chk(got_rdata, 32'h0000_0012);
    apb(1'b1, A_OC, 32'hffff_ffff);
    apb(1'b0, A_OC, 32'h0000_0000);
    chk(got_rdata, 32'h0000_0004);
  endtask : t_power

  // each mode bit alone, then all ones which must keep only bits 5,3,2
  task automatic t_mode();
    logic [7:0] wv [4];
    logic [2:0] cv [4];
    wv = '{8'h20, 8'h08, 8'h04, 8'hff};
    cv = '{3'h4, 3'h2, 3'h1, 3'h7};
    foreach (wv[i]) begin
      apb(1'b1, A_MODE, {24'h0, wv[i]});
      apb(1'b0, A_MODE, 32'h0000_0000);
      chk(got_rdata, {24'h0, wv[i] & 8'h2c});
      chk({29'h0, mode_ctl}, {29'h0, cv[i]});
    end
  endtask : t_mode

  // type codes with enhanced detection on and off
  task automatic t_type();
    logic [7:0] mv [4];
    logic [2:0] rv [4];
    logic [2:0] ev [4];
    mv = '{8'h04, 8'h04, 8'h00, 8'h00};
    rv = '{3'h2, 3'h1, 3'h2, 3'h3};
    ev = '{3'h2, 3'h1, 3'h1, 3'h3};
    foreach (mv[i]) begin
      apb(1'b1, A_MODE, {24'h0, mv[i]});
      @(posedge clk);
      raw_charger_type <= rv[i];
      wait_cyc(2);
      chk({29'h0, charger_type_code}, {29'h0, ev[i]});
    end
  endtask : t_type

  // unmapped and misaligned places answer with an error and drop writes
  task automatic t_bad();
    apb(1'b1, 16'hc39c, 32'hffff_ffff);
    chk({31'h0, got_err}, 32'h0000_0001);
    apb(1'b1, 16'hc3b1, 32'hffff_ffff);
    chk({31'h0, got_err}, 32'h0000_0001);
    apb(1'b0, A_MODE, 32'h0000_0000);
    chk(got_rdata, 32'h0000_0000);
  endtask : t_bad

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_cmp();
    t_power();
    t_mode();
    t_type();
    t_bad();
    give_verdict();
  end
endmodule : upstream_charger_port_power_status_test
